// File: rtl/aacr_pkg.sv
// Constants for the acquisition configuration register bank
package aacr_pkg;
  // Register indices on the register port
  localparam logic [3:0] IDX_CONTROL = 4'h0;
  localparam logic [3:0] IDX_VECTOR = 4'h1;
  localparam logic [3:0] IDX_CHANNELS = 4'h2;
  localparam logic [3:0] IDX_DECIM = 4'h3;
  localparam logic [3:0] IDX_CONV_CFG = 4'h4;
  localparam logic [3:0] IDX_CAL_SEL = 4'h5;
  localparam logic [3:0] IDX_PORT_ADDR = 4'h6;
  localparam logic [3:0] IDX_PORT_CHANS = 4'h7;
  localparam logic [3:0] IDX_BLOCK_CNT = 4'h8;
  localparam logic [3:0] IDX_SUB_BASE = 4'h9;
  localparam logic [3:0] IDX_SUB_SPACE = 4'ha;
  localparam logic [3:0] IDX_SYNC_WORD = 4'hb;
  // Control word fields and reset value
  localparam int CW_OSR_BIT = 8;
  localparam int CW_SUB_IRQ_BIT = 14;
  localparam int CW_VME_IRQ_BIT = 15;
  localparam logic [15:0] CW_RESET = 16'h0000;
  // Calibration selector fields
  localparam int CAL_TEST_EN_BIT = 6;
  localparam int CAL_STORED_BIT = 7;
  localparam logic [7:0] CAL_RESET = 8'h00;
  // Half-full thresholds in samples
  localparam logic [16:0] HALF_UNPACKED = 17'h04000;
  localparam logic [16:0] HALF_PACKED = 17'h08000;
  // Converter configuration port
  localparam int CONV_CS_BIT = 15;
  localparam logic [15:0] CONV_ARM = 16'h8000;
  localparam logic [7:0] CONV_REG_CAL = 8'h00;
  localparam logic [7:0] CONV_REG_HPF = 8'h01;
  localparam logic CONV_HPF_RESET = 1'b1;
  typedef enum logic [1:0] {CV_IDLE, CV_ARMED, CV_DATA} aacr_conv_e;
endpackage : aacr_pkg

// File: rtl/aacr_conv_if.sv
// Carrier between register bank and converter configuration port
`timescale 1ns/1ps
`default_nettype none
interface aacr_conv_if;
  logic wr;
  logic [15:0] data;
  logic conv_cs;
  logic conv_cal;
  logic conv_hpf_en;
  modport regs (output wr, output data, input conv_cs, input conv_cal, input conv_hpf_en);
  modport port (input wr, input data, output conv_cs, output conv_cal, output conv_hpf_en);
endinterface : aacr_conv_if
`default_nettype wire

// File: rtl/aacr_conv_cfg.sv
// Converter configuration write sequencer
`timescale 1ns/1ps
`default_nettype none
module aacr_conv_cfg
  import aacr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bank side
  aacr_conv_if.port cv
);
  aacr_conv_e state_reg;
  logic [7:0] addr_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= CV_IDLE;
      addr_reg <= 8'h00;
    end else if (cv.wr) begin
      if (!cv.data[CONV_CS_BIT]) begin
        state_reg <= CV_IDLE;
      end else begin
        case (state_reg)
          CV_IDLE: begin
            if (cv.data == CONV_ARM) begin
              state_reg <= CV_ARMED;
            end
          end
          CV_ARMED: begin
            addr_reg <= cv.data[7:0];
            state_reg <= CV_DATA;
          end
          CV_DATA: begin
            addr_reg <= addr_reg + 8'h01;
          end
          default: state_reg <= CV_IDLE;
        endcase
      end
    end
  end

  // Chip select follows the written bit, shared by all converters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cv.conv_cs <= 1'b0;
    end else if (cv.wr) begin
      cv.conv_cs <= cv.data[CONV_CS_BIT];
    end
  end

  // Only two notional registers exist; other addresses are dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cv.conv_cal <= 1'b0;
      cv.conv_hpf_en <= CONV_HPF_RESET;
    end else if (cv.wr && cv.data[CONV_CS_BIT] && state_reg == CV_DATA) begin
      if (addr_reg == CONV_REG_CAL) begin
        cv.conv_cal <= cv.data[0];
      end else if (addr_reg == CONV_REG_HPF) begin
        cv.conv_hpf_en <= cv.data[0];
      end
    end
  end
endmodule : aacr_conv_cfg
`default_nettype wire

// File: rtl/aacr_regs.sv
// Acquisition configuration register bank and its frame gating logic
`timescale 1ns/1ps
`default_nettype none
module aacr_regs
  import aacr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic board_reset,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_idx,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Sample stream from the converters
  input wire logic frame_start,
  input wire logic sample_valid,
  input wire logic [4:0] sample_chan,
  // FIFO status and output mode
  input wire logic [16:0] fifo_level,
  input wire logic packed_mode,
  input wire logic port_mode,
  // Daughter card presence pin
  input wire logic card_present_pin,
  // Converter controls
  output logic osr_128,
  output logic conv_cs,
  output logic conv_cal,
  output logic conv_hpf_en,
  // Storage and banking
  output logic store_en,
  output logic bank_switch,
  // Interrupt requests
  output logic vme_irq,
  output logic sub_irq,
  output logic [7:0] irq_vector,
  // Calibration signal routing
  output logic [2:0] cal_wave,
  output logic cal_input_sel,
  output logic cal_stored_sel,
  // Front-panel port setup
  output logic [4:0] port_addr,
  output logic [9:0] port_chans,
  // Subsystem bus setup
  output logic sub_en,
  output logic [15:0] sub_base,
  output logic [7:0] sub_space
);
  logic [15:0] control_word_reg;
  logic [7:0] interrupt_vector_reg;
  logic [4:0] channel_count_reg;
  logic [3:0] decimation_factor_reg;
  logic [7:0] cal_signal_select_reg;
  logic [4:0] port_board_address_reg;
  logic [9:0] port_channel_total_reg;
  logic [7:0] frames_per_block_reg;
  logic [15:0] subsystem_base_address_reg;
  logic [7:0] subsystem_space_code_reg;
  logic sub_en_reg;
  logic card_meta_reg;
  logic card_sync_reg;
  logic [3:0] decim_cnt_reg;
  logic frame_keep_reg;
  logic [7:0] block_cnt_reg;
  logic half_full;
  logic wr_ctl;

  aacr_conv_if cv_bus ();

  function automatic logic hit(input logic [3:0] idx, input logic [3:0] want);
    hit = reg_wr && (idx == want);
  endfunction : hit

  // Software board reset acts like the bus reset on the control word
  assign wr_ctl = hit(reg_idx, IDX_CONTROL);

  // Card presence comes from a pin on another domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      card_meta_reg <= 1'b0;
      card_sync_reg <= 1'b0;
    end else begin
      card_meta_reg <= card_present_pin;
      card_sync_reg <= card_meta_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control_word_reg <= CW_RESET;
    end else if (board_reset) begin
      control_word_reg <= CW_RESET;
    end else if (wr_ctl) begin
      control_word_reg <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interrupt_vector_reg <= 8'h00;
    end else if (hit(reg_idx, IDX_VECTOR)) begin
      interrupt_vector_reg <= reg_wdata[7:0];
    end
  end

  // Channel count and decimation have no documented reset; zero is safe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channel_count_reg <= 5'h00;
      decimation_factor_reg <= 4'h0;
    end else begin
      if (hit(reg_idx, IDX_CHANNELS)) begin
        channel_count_reg <= reg_wdata[4:0];
      end
      if (hit(reg_idx, IDX_DECIM)) begin
        decimation_factor_reg <= reg_wdata[3:0];
      end
    end
  end

  // Writes are ignored while the daughter card is missing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_signal_select_reg <= CAL_RESET;
    end else if (!card_sync_reg) begin
      cal_signal_select_reg <= CAL_RESET;
    end else if (hit(reg_idx, IDX_CAL_SEL)) begin
      cal_signal_select_reg <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_board_address_reg <= 5'h00;
      port_channel_total_reg <= 10'h000;
      frames_per_block_reg <= 8'h00;
    end else begin
      if (hit(reg_idx, IDX_PORT_ADDR)) begin
        port_board_address_reg <= reg_wdata[4:0];
      end
      if (hit(reg_idx, IDX_PORT_CHANS)) begin
        port_channel_total_reg <= reg_wdata[9:0];
      end
      if (hit(reg_idx, IDX_BLOCK_CNT)) begin
        frames_per_block_reg <= reg_wdata[7:0];
      end
    end
  end

  // The interface stays off after any reset until the base is written
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      subsystem_base_address_reg <= 16'h0000;
      sub_en_reg <= 1'b0;
    end else if (board_reset) begin
      sub_en_reg <= 1'b0;
    end else if (hit(reg_idx, IDX_SUB_BASE)) begin
      subsystem_base_address_reg <= reg_wdata[31:16];
      sub_en_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      subsystem_space_code_reg <= 8'h00;
    end else if (hit(reg_idx, IDX_SUB_SPACE)) begin
      subsystem_space_code_reg <= reg_wdata[7:0];
    end
  end

  // Sync word writes decode to no register, so they change nothing

  // Converter port writes go to the shared sequencer
  assign cv_bus.wr = hit(reg_idx, IDX_CONV_CFG);
  assign cv_bus.data = reg_wdata[15:0];

  aacr_conv_cfg u_conv (
    .clk(clk),
    .rst(rst),
    .cv(cv_bus.port)
  );

  // Write-only registers read as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_idx == IDX_CONTROL) begin
        reg_rdata <= {16'h0000, control_word_reg};
      end else if (reg_idx == IDX_VECTOR) begin
        reg_rdata <= {24'h000000, interrupt_vector_reg};
      end else if (reg_idx == IDX_CAL_SEL && card_sync_reg) begin
        reg_rdata <= {24'h000000, cal_signal_select_reg};
      end else if (reg_idx == IDX_SYNC_WORD) begin
        reg_rdata <= 32'h00000000;
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

  // Decimation: frame kept when the counter is back at zero
  // Board reset drops the frame in flight and restarts the phase, as at power-up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      decim_cnt_reg <= 4'h0;
      frame_keep_reg <= 1'b0;
    end else if (board_reset) begin
      decim_cnt_reg <= 4'h0;
      frame_keep_reg <= 1'b0;
    end else if (frame_start) begin
      frame_keep_reg <= (decim_cnt_reg == 4'h0);
      if (decim_cnt_reg >= decimation_factor_reg) begin
        decim_cnt_reg <= 4'h0;
      end else begin
        decim_cnt_reg <= decim_cnt_reg + 4'h1;
      end
    end
  end

  // Frame start and its samples arrive in distinct cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      store_en <= 1'b0;
    end else begin
      store_en <= sample_valid && frame_keep_reg &&
                  (sample_chan <= channel_count_reg);
    end
  end

  // Counts kept frames in port mode; a switch on every count-plus-one frames
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      block_cnt_reg <= 8'h00;
      bank_switch <= 1'b0;
    end else if (board_reset) begin
      block_cnt_reg <= 8'h00;
      bank_switch <= 1'b0;
    end else begin
      bank_switch <= 1'b0;
      if (port_mode && sample_valid && frame_keep_reg &&
          sample_chan == channel_count_reg) begin
        if (block_cnt_reg >= frames_per_block_reg) begin
          block_cnt_reg <= 8'h00;
          bank_switch <= 1'b1;
        end else begin
          block_cnt_reg <= block_cnt_reg + 8'h01;
        end
      end
    end
  end

  // Levels, not pulses: the host removes the cause by draining the FIFO
  assign half_full = packed_mode ? (fifo_level >= HALF_PACKED) :
                     (fifo_level >= HALF_UNPACKED);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vme_irq <= 1'b0;
      sub_irq <= 1'b0;
    end else begin
      vme_irq <= half_full && control_word_reg[CW_VME_IRQ_BIT];
      sub_irq <= half_full && control_word_reg[CW_SUB_IRQ_BIT] && sub_en_reg;
    end
  end

  // Outputs copied from registers so every pin comes from a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osr_128 <= 1'b0;
      irq_vector <= 8'h00;
      cal_wave <= 3'h0;
      cal_input_sel <= 1'b0;
      cal_stored_sel <= 1'b0;
      port_addr <= 5'h00;
      port_chans <= 10'h000;
      sub_en <= 1'b0;
      sub_base <= 16'h0000;
      sub_space <= 8'h00;
      conv_cs <= 1'b0;
      conv_cal <= 1'b0;
      conv_hpf_en <= CONV_HPF_RESET;
    end else begin
      osr_128 <= control_word_reg[CW_OSR_BIT];
      irq_vector <= interrupt_vector_reg;
      cal_wave <= cal_signal_select_reg[2:0];
      cal_input_sel <= cal_signal_select_reg[CAL_TEST_EN_BIT];
      cal_stored_sel <= cal_signal_select_reg[CAL_TEST_EN_BIT] &&
                        cal_signal_select_reg[CAL_STORED_BIT];
      port_addr <= port_board_address_reg;
      port_chans <= port_channel_total_reg;
      sub_en <= sub_en_reg;
      sub_base <= subsystem_base_address_reg;
      sub_space <= subsystem_space_code_reg;
      conv_cs <= cv_bus.conv_cs;
      conv_cal <= cv_bus.conv_cal;
      conv_hpf_en <= cv_bus.conv_hpf_en;
    end
  end
endmodule : aacr_regs
`default_nettype wire

// File: tb/aacr_regs_asserts.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module aacr_regs_asserts
  import aacr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic board_reset,
  // Register port
  input wire logic reg_wr,
  input wire logic [3:0] reg_idx,
  input wire logic [31:0] reg_wdata,
  // Stream and status
  input wire logic sample_valid,
  input wire logic [16:0] fifo_level,
  input wire logic packed_mode,
  input wire logic port_mode,
  // Watched outputs
  input wire logic osr_128,
  input wire logic conv_cs,
  input wire logic store_en,
  input wire logic bank_switch,
  input wire logic vme_irq,
  input wire logic sub_irq,
  input wire logic [7:0] irq_vector,
  input wire logic sub_en,
  input wire logic [15:0] sub_base
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [16:0] thr;
  assign thr = packed_mode ? HALF_PACKED : HALF_UNPACKED;
  // A board reset right after the write would legally wipe it
  sequence s_wr(logic [3:0] i);
    reg_wr && reg_idx == i && !board_reset ##1 !board_reset;
  endsequence
  property p_osr;
    s_wr(IDX_CONTROL) |=> osr_128 == $past(reg_wdata[CW_OSR_BIT], 2);
  endproperty
  a_osr: assert property (p_osr) else $error("osr_128 not from control write");
  property p_vme;
    vme_irq |-> $past(fifo_level) >= $past(thr);
  endproperty
  a_vme: assert property (p_vme) else $error("vme_irq below half full");
  property p_sub;
    sub_irq |-> $past(fifo_level) >= $past(thr);
  endproperty
  a_sub: assert property (p_sub) else $error("sub_irq below half full");
  property p_store;
    store_en |-> $past(sample_valid);
  endproperty
  a_store: assert property (p_store) else $error("store_en without sample");
  property p_bank;
    bank_switch |-> $past(port_mode);
  endproperty
  a_bank: assert property (p_bank) else $error("bank_switch outside port mode");
  property p_base;
    s_wr(IDX_SUB_BASE) |=> sub_en && sub_base == $past(reg_wdata[31:16], 2);
  endproperty
  a_base: assert property (p_base) else $error("base write not applied");
  property p_vec;
    s_wr(IDX_VECTOR) |=> irq_vector == $past(reg_wdata[7:0], 2);
  endproperty
  a_vec: assert property (p_vec) else $error("vector not applied");
  property p_brst;
    board_reset |-> ##2 !osr_128 && !vme_irq;
  endproperty
  a_brst: assert property (p_brst) else $error("board reset left control bits");
  property p_conv;
    reg_wr && reg_idx == IDX_CONV_CFG |-> ##2 conv_cs == $past(reg_wdata[CONV_CS_BIT], 2);
  endproperty
  a_conv: assert property (p_conv) else $error("conv_cs not from write");
  c_irq: cover property (vme_irq && sub_irq);
  c_bank: cover property (bank_switch);
  c_store: cover property (store_en ##1 store_en);
endmodule : aacr_regs_asserts
bind aacr_regs aacr_regs_asserts i_aacr_regs_asserts (.clk(clk), .rst(rst),
  .board_reset(board_reset), .reg_wr(reg_wr), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
  .sample_valid(sample_valid), .fifo_level(fifo_level), .packed_mode(packed_mode),
  .port_mode(port_mode), .osr_128(osr_128), .conv_cs(conv_cs), .store_en(store_en),
  .bank_switch(bank_switch), .vme_irq(vme_irq), .sub_irq(sub_irq),
  .irq_vector(irq_vector), .sub_en(sub_en), .sub_base(sub_base));
`default_nettype wire

// File: tb/aacr_host.sv
// Host processor model driving the register port
`timescale 1ns/1ps
`default_nettype none
module aacr_host
  import aacr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [3:0] reg_idx,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_idx = 4'h0;
    reg_wdata = 32'h0;
  end
  // Released lines show the inverse so stale values cannot pass
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    @(posedge clk);
    #1;
    reg_wr = 1'b1;
    reg_idx = i;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_idx = ~i;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [3:0] i, output logic [31:0] d);
    @(posedge clk);
    #1;
    reg_rd = 1'b1;
    reg_idx = i;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_idx = ~i;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic setup(input logic [7:0] v, input logic [15:0] cw);
    wr(IDX_VECTOR, {24'h0, v});
    wr(IDX_CONTROL, {16'h0, cw});
  endtask : setup
  // Arm, address 0, calibrate, then high-pass off at address 1, close
  task automatic conv_prog;
    wr(IDX_CONV_CFG, {16'h0, CONV_ARM});
    wr(IDX_CONV_CFG, 32'h00008000);
    wr(IDX_CONV_CFG, 32'h00008001);
    wr(IDX_CONV_CFG, 32'h00008000);
    wr(IDX_CONV_CFG, 32'h0);
  endtask : conv_prog
endmodule : aacr_host
`default_nettype wire

// File: tb/adc_acquisition_config_regs_tb.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module adc_acquisition_config_regs_tb;
  import aacr_pkg::*;
  logic clk, rst, board_reset, reg_wr, reg_rd, frame_start, sample_valid;
  logic packed_mode, port_mode, card_present_pin, osr_128, conv_cs, conv_cal, conv_hpf_en;
  logic store_en, bank_switch, vme_irq, sub_irq, cal_input_sel, cal_stored_sel, sub_en;
  logic [3:0] reg_idx;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [4:0] sample_chan, port_addr;
  logic [16:0] fifo_level;
  logic [7:0] irq_vector, sub_space;
  logic [2:0] cal_wave;
  logic [9:0] port_chans;
  logic [15:0] sub_base;
  int failures = 0;
  int cmp_count = 0;
  int n_store = 0;
  int n_bank = 0;
  aacr_regs i_aacr_regs (.clk(clk), .rst(rst), .board_reset(board_reset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .frame_start(frame_start), .sample_valid(sample_valid), .sample_chan(sample_chan),
    .fifo_level(fifo_level), .packed_mode(packed_mode), .port_mode(port_mode),
    .card_present_pin(card_present_pin), .osr_128(osr_128), .conv_cs(conv_cs),
    .conv_cal(conv_cal), .conv_hpf_en(conv_hpf_en), .store_en(store_en),
    .bank_switch(bank_switch), .vme_irq(vme_irq), .sub_irq(sub_irq), .irq_vector(irq_vector),
    .cal_wave(cal_wave), .cal_input_sel(cal_input_sel), .cal_stored_sel(cal_stored_sel),
    .port_addr(port_addr), .port_chans(port_chans), .sub_en(sub_en), .sub_base(sub_base),
    .sub_space(sub_space));
  aacr_host i_aacr_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (store_en === 1'b1) n_store++;
    if (bank_switch === 1'b1) n_bank++;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic wrap_up;
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic t_reset;
    chk("conv_hpf_en", 1, conv_hpf_en);
    chk("osr_128", 0, osr_128);
    chk("irqs", 0, {vme_irq, sub_irq});
  endtask : t_reset
  task automatic t_irq;
    i_aacr_host.setup(8'h5a, 16'hc100);
    settle();
    chk("osr_128", 1, osr_128);
    chk("irq_vector", 8'h5a, irq_vector);
    fifo_level = HALF_UNPACKED - 17'h1;
    settle();
    chk("vme_irq low", 0, vme_irq);
    fifo_level = HALF_UNPACKED;
    settle();
    chk("vme_irq", 1, vme_irq);
    chk("sub_irq off", 0, sub_irq);
    packed_mode = 1'b1;
    settle();
    chk("vme_irq packed", 0, vme_irq);
    fifo_level = HALF_PACKED;
    i_aacr_host.wr(IDX_SUB_BASE, 32'habcd0000);
    settle();
    chk("sub_base", 16'habcd, sub_base);
    chk("sub_irq", 1, sub_irq);
    i_aacr_host.rd(IDX_CONTROL, d);
    chk("control read", 32'hc100, d);
    board_reset = 1'b1;
    @(posedge clk);
    #1;
    board_reset = 1'b0;
    settle();
    chk("brst osr", 0, osr_128);
    chk("brst sub_en", 0, sub_en);
    fifo_level = 17'h0;
  endtask : t_irq
  task automatic t_conv;
    i_aacr_host.conv_prog();
    settle();
    chk("conv pins", 3'b010, {conv_cs, conv_cal, conv_hpf_en});
  endtask : t_conv
  task automatic t_cal;
    i_aacr_host.wr(IDX_CAL_SEL, 32'hc5);
    i_aacr_host.rd(IDX_CAL_SEL, d);
    chk("cal absent", 0, d);
    card_present_pin = 1'b1;
    settle();
    i_aacr_host.wr(IDX_CAL_SEL, 32'hc5);
    settle();
    chk("cal_wave", 3'h5, cal_wave);
    chk("cal route", 2'b11, {cal_input_sel, cal_stored_sel});
    i_aacr_host.rd(IDX_CAL_SEL, d);
    chk("cal read", 32'hc5, d);
    i_aacr_host.wr(IDX_CAL_SEL, 32'h83);
    settle();
    chk("cal_wave 3", 3'h3, cal_wave);
    chk("cal route off", 2'b00, {cal_input_sel, cal_stored_sel});
  endtask : t_cal
  task automatic frame;
    @(posedge clk);
    #1;
    frame_start = 1'b1;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      #1;
      frame_start = 1'b0;
      sample_valid = 1'b1;
      sample_chan = c[4:0];
    end
    @(posedge clk);
    #1;
    sample_valid = 1'b0;
  endtask : frame
  task automatic t_stream;
    i_aacr_host.wr(IDX_CHANNELS, 32'h1);
    i_aacr_host.wr(IDX_DECIM, 32'h1);
    i_aacr_host.wr(IDX_BLOCK_CNT, 32'h0);
    port_mode = 1'b1;
    n_store = 0;
    n_bank = 0;
    frame();
    frame();
    settle();
    chk("stored", 2, n_store);
    chk("banks", 1, n_bank);
    i_aacr_host.wr(IDX_CHANNELS, 32'h1f);
    i_aacr_host.wr(IDX_DECIM, 32'h0);
    n_store = 0;
    n_bank = 0;
    frame();
    settle();
    chk("stored all", 4, n_store);
    chk("no bank", 0, n_bank);
  endtask : t_stream
  task automatic t_misc;
    i_aacr_host.wr(IDX_PORT_ADDR, 32'h1f);
    i_aacr_host.wr(IDX_PORT_CHANS, 32'h3ff);
    i_aacr_host.wr(IDX_SUB_SPACE, 32'h3c);
    i_aacr_host.wr(IDX_SYNC_WORD, 32'hffffffff);
    settle();
    chk("port setup", {5'h1f, 10'h3ff, 8'h3c}, {port_addr, port_chans, sub_space});
    chk("sync no effect", 0, {osr_128, vme_irq, sub_en});
    i_aacr_host.rd(IDX_SYNC_WORD, d);
    chk("sync read", 0, d);
    i_aacr_host.rd(IDX_CHANNELS, d);
    chk("write only read", 0, d);
    i_aacr_host.rd(4'hc, d);
    chk("unmapped read", 0, d);
  endtask : t_misc
  initial begin
    rst = 1'b1;
    board_reset = 1'b0;
    frame_start = 1'b0;
    sample_valid = 1'b0;
    sample_chan = 5'h0;
    fifo_level = 17'h0;
    packed_mode = 1'b0;
    port_mode = 1'b0;
    card_present_pin = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    #2;
    t_reset();
    t_irq();
    t_conv();
    t_cal();
    t_stream();
    t_misc();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule : adc_acquisition_config_regs_tb
`default_nettype wire
